// ---- rtl/reader_command_sequencer.sv ----
// command sequencer: boot, idle, authentication, config load, crc, key load
`timescale 1ns/1ps
`include "reader_command_sequencer_cfg.svh"

// Summary of operation
// - first authentication takes six fifo argument bytes
// - second authentication uses no fifo data
// - config load takes two address bytes, loads registers
// - crc command fills low and high results
// - boot code never started by host write
// - boot starts after supply or pin reset
// - boot reset phase sets fixed register values
// - boot init loads registers from eeprom
// - idle follows boot completion automatically
// - during boot only page zero reads allowed
// - boot cannot be interrupted by host
// - idle code waits with no fifo traffic
// - self completion sets idle interrupt flag, except at the end of boot
// - host idle abort sets no flag
// - abort leaves fifo untouched
// - key load reads twelve fifo bytes lsb first
module reader_command_sequencer
  import reader_command_sequencer_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        digital_supply_pin_in,   // power-on good, low during power-up
  input  wire logic        analog_supply_pin_in,
  input  wire logic        hard_reset_powerdown_pin_in,
  input  wire logic        cmd_write_in,
  input  wire logic [7:0]  cmd_data_in,
  input  wire logic        reg_read_in,
  input  wire logic [5:0]  reg_addr_in,
  input  wire fifo_byte_t  fifo_in,
  input  wire logic        ee_ack_in,
  input  wire logic [7:0]  ee_data_in,
  input  wire logic        auth_two_done_in,
  output logic             fifo_pop_out,
  output logic [7:0]       cmd_readback_out,
  output logic             idle_interrupt_flag_out,
  output logic             access_allowed_out,
  output ee_req_t          ee_out,
  output reg_load_t        reg_load_out,
  output logic [7:0]       crc_out_low_out,
  output logic [7:0]       crc_out_high_out,
  output logic             auth_one_start_out,
  output logic [47:0]      auth_args_out,
  output logic             auth_two_start_out,
  output logic [95:0]      key_buffer_out
);

  seq_state_t  state_reg, state_next;
  logic [7:0]  cmd_reg;
  logic [2:0]  arg_cnt_reg;
  logic [3:0]  word_cnt_reg;
  logic [15:0] ee_addr_reg;
  logic [15:0] crc_reg;
  logic        pin_q_reg;
  logic        flag_reg;
  logic        pop_reg;
  logic        ee_req_reg;
  logic        auth_one_reg;
  logic        auth_two_reg;
  logic [47:0] args_reg;
  logic [95:0] key_reg;
  logic        allow_reg;
  logic [7:0]  load_addr_reg;
  logic [7:0]  load_data_reg;
  logic        load_we_reg;

  // any reset source restarts the boot sequence
  wire pin_fall   = pin_q_reg & ~hard_reset_powerdown_pin_in;
  wire boot_trig  = ~digital_supply_pin_in | ~analog_supply_pin_in | pin_fall;
  wire in_boot    = (state_reg == ST_BOOT_RESET) | (state_reg == ST_BOOT_INIT);
  // host writes ignored while booting, boot code never accepted
  wire host_cmd   = cmd_write_in & ~in_boot & (cmd_data_in != `CMD_BOOT);
  wire host_abort = host_cmd & (cmd_data_in == `CMD_IDLE);
  wire busy       = (state_reg != ST_IDLE) & ~in_boot;
  wire byte_take  = fifo_in.valid & ~pop_reg;     // one pop per byte, avoids double reads
  wire is_args    = state_reg == ST_ARGS;
  wire args_last  = is_args & byte_take & (
                    ((cmd_reg == `CMD_AUTH_ONE) & (arg_cnt_reg == `AUTH_ONE_ARGS - 3'h1)) |
                    ((cmd_reg == `CMD_LOAD_CONFIG) & (arg_cnt_reg == `CONFIG_ARGS - 3'h1)) |
                    ((cmd_reg == `CMD_LOAD_KEY) & (word_cnt_reg == `KEY_BYTES - 4'h1)));
  wire ee_last    = ee_ack_in & (word_cnt_reg == `CONFIG_WORDS);
  // crc ends when the fifo runs dry
  wire crc_done   = (state_reg == ST_CRC) & ~fifo_in.valid & ~pop_reg;
  wire auth_done  = (state_reg == ST_AUTH_TWO) & auth_two_done_in;
  wire key_done   = args_last & (cmd_reg == `CMD_LOAD_KEY);
  wire ee_done    = (state_reg == ST_EE_LOAD) & ee_last & ~(cmd_reg == `CMD_BOOT);
  wire auth1_done = args_last & (cmd_reg == `CMD_AUTH_ONE);
  wire self_done  = crc_done | auth_done | key_done | ee_done | auth1_done;

  // one reflected crc step over the byte entering
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction

  // next state selection
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_BOOT_RESET: state_next = ST_BOOT_INIT;
      ST_BOOT_INIT:  if (ee_last) state_next = ST_IDLE;
      ST_IDLE: begin
        if (host_cmd) begin
          unique case (cmd_data_in)
            `CMD_AUTH_ONE, `CMD_LOAD_CONFIG, `CMD_LOAD_KEY: state_next = ST_ARGS;
            `CMD_CRC_COMPUTE: state_next = ST_CRC;
            `CMD_AUTH_TWO:    state_next = ST_AUTH_TWO;
            default:          state_next = ST_IDLE;
          endcase
        end
      end
      ST_ARGS:     if (args_last) state_next =
                     (cmd_reg == `CMD_LOAD_CONFIG) ? ST_EE_LOAD : ST_IDLE;
      ST_EE_LOAD:  if (ee_last) state_next = ST_IDLE;
      ST_CRC:      if (crc_done) state_next = ST_IDLE;
      ST_AUTH_TWO: if (auth_done) state_next = ST_IDLE;
      default:     state_next = ST_BOOT_RESET;
    endcase
    if (host_abort & busy) begin
      state_next = ST_IDLE;
    end
    if (boot_trig) begin
      state_next = ST_BOOT_RESET;
    end
  end

  // state and command register; reads back the running code
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_BOOT_RESET;
      cmd_reg   <= `CMD_BOOT;
    end else begin
      state_reg <= state_next;
      if (state_next == ST_BOOT_RESET) begin
        cmd_reg <= `CMD_BOOT;
      end else if (state_next == ST_IDLE) begin
        cmd_reg <= `CMD_IDLE;
      end else if (host_cmd) begin
        cmd_reg <= cmd_data_in;
      end
    end
  end

  // reset pin edge detector
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pin_q_reg <= 1'b1;                 // idle level of the pin, no false edge
    end else begin
      pin_q_reg <= hard_reset_powerdown_pin_in;
    end
  end

  // idle flag sticky until a new command; completion wins over the clear
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || boot_trig) begin
      flag_reg <= 1'b0;
    end else if (self_done) begin
      flag_reg <= 1'b1;
    end else if (host_cmd && !host_abort) begin
      flag_reg <= 1'b0;
    end
  end

  // fifo pops only while consuming; abort never pops so fifo stays intact
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || boot_trig || host_abort) begin
      pop_reg <= 1'b0;
    end else begin
      pop_reg <= byte_take & (is_args | (state_reg == ST_CRC)) & ~args_last | args_last;
    end
  end

  // argument capture: auth bytes in order, key lsb first, address low first
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      arg_cnt_reg <= 3'h0;
      args_reg    <= 48'h0;
    end else if (state_reg == ST_IDLE) begin
      arg_cnt_reg <= 3'h0;               // arguments stay visible after the command
    end else if (is_args && byte_take) begin
      arg_cnt_reg <= arg_cnt_reg + 3'h1;
      if (cmd_reg == `CMD_AUTH_ONE) begin
        args_reg[arg_cnt_reg*8 +: 8] <= fifo_in.data;
      end
    end
  end

  // key buffer and eeprom address
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      key_reg     <= 96'h0;
      ee_addr_reg <= `BOOT_EE_ADDR;
    end else if (state_reg == ST_BOOT_RESET) begin
      ee_addr_reg <= `BOOT_EE_ADDR;
    end else if (is_args && byte_take) begin
      if (cmd_reg == `CMD_LOAD_KEY) begin
        key_reg[word_cnt_reg*8 +: 8] <= fifo_in.data;
      end
      if (cmd_reg == `CMD_LOAD_CONFIG) begin
        ee_addr_reg[arg_cnt_reg[0]*8 +: 8] <= fifo_in.data;
      end
    end else if (ee_ack_in) begin
      ee_addr_reg <= ee_addr_reg + 16'h0001;
    end
  end

  // byte counter shared by key load and eeprom word walk
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || state_reg == ST_IDLE || state_reg == ST_BOOT_RESET || args_last) begin
      word_cnt_reg <= 4'h0;
    end else if ((is_args && byte_take) || ee_ack_in) begin
      word_cnt_reg <= word_cnt_reg + 4'h1;
    end
  end

  // eeprom requests and register loads; boot reset writes fixed values
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ee_req_reg    <= 1'b0;
      load_we_reg   <= 1'b0;
      load_addr_reg <= 8'h00;
      load_data_reg <= 8'h00;
    end else begin
      ee_req_reg    <= (state_next == ST_BOOT_INIT || state_next == ST_EE_LOAD)
                       & ~ee_last;
      load_we_reg   <= ee_ack_in | (state_reg == ST_BOOT_RESET);
      load_addr_reg <= (state_reg == ST_BOOT_RESET) ? 8'h00 : {4'h0, word_cnt_reg};
      load_data_reg <= (state_reg == ST_BOOT_RESET) ? `BOOT_RESET_VALUE : ee_data_in;
    end
  end

  // crc coprocessor over fifo bytes
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      crc_reg <= `CRC_PRESET;
    end else if (host_cmd && cmd_data_in == `CMD_CRC_COMPUTE) begin
      crc_reg <= `CRC_PRESET;
    end else if (state_reg == ST_CRC && byte_take) begin
      crc_reg <= crc_step(crc_reg, fifo_in.data);
    end
  end

  // authentication start pulses and access gate
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      auth_one_reg <= 1'b0;
      auth_two_reg <= 1'b0;
      allow_reg    <= 1'b0;
    end else begin
      auth_one_reg <= auth1_done;
      auth_two_reg <= host_cmd & (cmd_data_in == `CMD_AUTH_TWO) & ~busy;
      allow_reg    <= in_boot ? (reg_read_in & (reg_addr_in == 6'h00)) : 1'b1;
    end
  end

  assign fifo_pop_out            = pop_reg;
  assign cmd_readback_out        = cmd_reg;
  assign idle_interrupt_flag_out = flag_reg;
  assign access_allowed_out      = allow_reg;
  assign ee_out                  = '{req: ee_req_reg, addr: ee_addr_reg};
  assign reg_load_out            = '{addr: load_addr_reg, data: load_data_reg, we: load_we_reg};
  assign crc_out_low_out         = crc_reg[7:0];
  assign crc_out_high_out        = crc_reg[15:8];
  assign auth_one_start_out      = auth_one_reg;
  assign auth_args_out           = args_reg;
  assign auth_two_start_out      = auth_two_reg;
  assign key_buffer_out          = key_reg;

endmodule

// ---- rtl/reader_command_sequencer_cfg.svh ----
// constants of the reader command sequencer
`ifndef READER_COMMAND_SEQUENCER_CFG_SVH
`define READER_COMMAND_SEQUENCER_CFG_SVH
`define CMD_IDLE          8'h00
`define CMD_LOAD_CONFIG   8'h07
`define CMD_AUTH_ONE      8'h0c
`define CMD_CRC_COMPUTE   8'h12
`define CMD_AUTH_TWO      8'h14
`define CMD_LOAD_KEY      8'h19
`define CMD_BOOT          8'h3f
`define AUTH_ONE_ARGS     3'h6
`define CONFIG_ARGS       3'h2
`define KEY_BYTES         4'hc
`define CRC_PRESET        16'h6363
`define CRC_POLY_REFL     16'h8408
`define BOOT_EE_ADDR      16'h0010
`define CONFIG_WORDS      4'hf
`define BOOT_RESET_VALUE  8'h00
`endif

// ---- rtl/reader_command_sequencer_pkg.sv ----
// types shared by the reader command sequencer
package reader_command_sequencer_pkg;
  typedef enum logic [2:0] {
    ST_BOOT_RESET = 3'b000,
    ST_BOOT_INIT  = 3'b001,
    ST_IDLE       = 3'b010,
    ST_ARGS       = 3'b011,
    ST_EE_LOAD    = 3'b100,
    ST_CRC        = 3'b101,
    ST_AUTH_TWO   = 3'b110
  } seq_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } fifo_byte_t;

  typedef struct packed {
    logic        req;
    logic [15:0] addr;
  } ee_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       we;
  } reg_load_t;
endpackage

// ---- testbench/reader_command_sequencer_asserts.sv ----
// port assertions for the reader command sequencer
`timescale 1ns/1ps
module reader_command_sequencer_asserts
  import reader_command_sequencer_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       rst_n_in,
  input wire logic       cmd_write_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic       reg_read_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic       ee_ack_in,
  input wire logic [7:0] ee_data_in,
  input wire logic       auth_two_done_in,
  input wire logic       fifo_pop_out,
  input wire logic [7:0] cmd_readback_out,
  input wire logic       idle_interrupt_flag_out,
  input wire logic       access_allowed_out,
  input wire ee_req_t    ee_out,
  input wire reg_load_t  reg_load_out,
  input wire logic       auth_two_start_out
);
  default clocking dc @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // named steps used by the properties; only s_ack_taken is shared, by two of them
  sequence s_idle_flagged;
    cmd_readback_out == 8'h00 && idle_interrupt_flag_out;
  endsequence
  sequence s_ack_taken;
    ee_out.req && ee_ack_in;
  endsequence
  AST_NO_HOST_BOOT: assert property (cmd_write_in && cmd_data_in == 8'h3f
    && cmd_readback_out == 8'h00 |=> cmd_readback_out == 8'h00) else $error("boot started by host");
  AST_BOOT_ENDS: assert property (cmd_readback_out == 8'h3f
    |-> ##[1:400] cmd_readback_out == 8'h00) else $error("boot did not reach idle");
  AST_BOOT_ACCESS: assert property ($past(cmd_readback_out) == 8'h3f
    && cmd_readback_out == 8'h3f && !($past(reg_read_in) && $past(reg_addr_in) == 6'h00)
    |-> !access_allowed_out) else $error("access granted during boot");
  AST_IDLE_NO_POP: assert property (cmd_readback_out == 8'h00
    && $past(cmd_readback_out) == 8'h00 |-> !fifo_pop_out) else $error("pop while idle");
  AST_TWO_NO_POP: assert property (cmd_readback_out == 8'h14
    && $past(cmd_readback_out) == 8'h14 |-> !fifo_pop_out) else $error("pop in phase two");
  AST_TWO_START: assert property (cmd_readback_out == 8'h00 && cmd_write_in
    && cmd_data_in == 8'h14 |-> ##[1:2] auth_two_start_out) else $error("phase two not started");
  AST_TWO_DONE: assert property (cmd_readback_out == 8'h14 && auth_two_done_in
    && !cmd_write_in |-> ##[1:2] s_idle_flagged) else $error("no flag on completion");
  AST_ABORT_QUIET: assert property (cmd_readback_out == 8'h14 && !auth_two_done_in
    && cmd_write_in && cmd_data_in == 8'h00 && !idle_interrupt_flag_out
    |=> cmd_readback_out == 8'h00 && !idle_interrupt_flag_out) else $error("abort set flag");
  AST_EE_STEP: assert property (s_ack_taken ##1 ee_out.req
    |-> ee_out.addr == $past(ee_out.addr) + 16'h0001) else $error("eeprom address not stepped");
  AST_LOAD_AFTER_ACK: assert property (s_ack_taken
    |=> reg_load_out.we && reg_load_out.data == $past(ee_data_in)) else $error("load missing");
endmodule

// ---- testbench/eeprom_responder.sv ----
// eeprom model answering byte requests of the sequencer
`timescale 1ns/1ps
module eeprom_responder
  import reader_command_sequencer_pkg::*;
(
  input  wire logic    clk_in,
  input  wire logic    rst_n_in,
  input  wire logic    slow_in,
  input  wire ee_req_t ee_in,
  output logic         ack_out,
  output logic [7:0]   data_out
);
  logic [2:0] wait_reg;
  // one-cycle ack after a short or long wait; data is garbage outside the ack
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wait_reg <= 3'h0;
      ack_out  <= 1'b0;
      data_out <= 8'h00;
    end else if (ee_in.req && !ack_out && wait_reg >= (slow_in ? 3'h4 : 3'h0)) begin
      ack_out  <= 1'b1;
      wait_reg <= 3'h0;
      data_out <= ee_in.addr[7:0] ^ 8'h5a;  // content follows the address
    end else begin
      ack_out  <= 1'b0;
      wait_reg <= ee_in.req ? wait_reg + 3'h1 : 3'h0;
      data_out <= ~data_out;
    end
  end
endmodule

// ---- testbench/test_reader_command_sequencer.sv ----
// self-checking bench for the reader command sequencer
`timescale 1ns/1ps
`include "reader_command_sequencer_cfg.svh"
module test_reader_command_sequencer
  import reader_command_sequencer_pkg::*;
;
  logic        ref_clk_in, rst_n_in, digital_supply_pin_in, analog_supply_pin_in;
  logic        hard_reset_powerdown_pin_in, cmd_write_in, reg_read_in, ee_ack_in;
  logic        auth_two_done_in, fifo_pop_out, idle_interrupt_flag_out, access_allowed_out;
  logic        auth_one_start_out, auth_two_start_out, slow_in;
  logic [7:0]  cmd_data_in, ee_data_in, cmd_readback_out, crc_out_low_out, crc_out_high_out;
  logic [7:0]  seed;
  logic [5:0]  reg_addr_in;
  logic [47:0] auth_args_out;
  logic [95:0] key_buffer_out;
  fifo_byte_t  fifo_in;
  ee_req_t     ee_out;
  reg_load_t   reg_load_out;
  logic [7:0]  q[$];
  logic [7:0]  sent[$];
  int          errors, comparisons, n;

  reader_command_sequencer uut (.ref_clk_in, .rst_n_in, .digital_supply_pin_in,
    .analog_supply_pin_in, .hard_reset_powerdown_pin_in, .cmd_write_in, .cmd_data_in,
    .reg_read_in, .reg_addr_in, .fifo_in, .ee_ack_in, .ee_data_in, .auth_two_done_in,
    .fifo_pop_out, .cmd_readback_out, .idle_interrupt_flag_out, .access_allowed_out, .ee_out,
    .reg_load_out, .crc_out_low_out, .crc_out_high_out, .auth_one_start_out, .auth_args_out,
    .auth_two_start_out, .key_buffer_out);
  eeprom_responder ee (.clk_in(ref_clk_in), .rst_n_in(rst_n_in), .slow_in(slow_in),
    .ee_in(ee_out), .ack_out(ee_ack_in), .data_out(ee_data_in));

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // reflected crc, low bit first, as the crc result registers should hold
  function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
    logic [15:0] c;
    c = `CRC_PRESET;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ `CRC_POLY_REFL : c >> 1;
    end
    return c;
  endfunction
  function automatic logic [95:0] packed_of(input logic [7:0] b[$]);
    logic [95:0] r;
    r = '0;
    foreach (b[i]) r[8*i +: 8] = b[i];
    return r;
  endfunction
  task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask
  // host command write, one cycle strobe
  task automatic cmd(input logic [7:0] c);
    tick(1);
    cmd_write_in = 1'b1;
    cmd_data_in  = c;
    tick(1);
    cmd_write_in = 1'b0;
  endtask
  task automatic fill(input int k);
    sent.delete();
    repeat (k) begin
      seed = lfsr_next(seed);
      sent.push_back(seed);
      q.push_back(seed);
    end
    tick(2);
  endtask
  // bounded wait; a hang shows up as a mismatch in the checks that follow; host polls for idle
  task automatic wait_idle;
    n = 0;
    while (cmd_readback_out !== 8'h00 && n < 600) begin
      tick(1);
      n++;
    end
  endtask
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // fifo head model; pops use the value registered before this edge
  always @(posedge ref_clk_in) begin
    if (fifo_pop_out === 1'b1 && q.size() > 0) void'(q.pop_front());
    #1;
    fifo_in.valid = (q.size() > 0);
    fifo_in.data  = (q.size() > 0) ? q[0] : ~fifo_in.data;
  end
  // watchdog, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    errors++;
    results;
  end

  initial begin
    {rst_n_in, cmd_write_in, reg_read_in, auth_two_done_in, slow_in} = '0;
    {digital_supply_pin_in, analog_supply_pin_in, hard_reset_powerdown_pin_in} = 3'h7;
    {cmd_data_in, reg_addr_in} = '0;
    seed = 8'h0c;
    tick(10);
    rst_n_in = 1'b1;
    check("boot code", cmd_readback_out, 8'h3f);
    cmd(8'h0c);
    check("boot ignores write", cmd_readback_out, 8'h3f);
    reg_read_in = 1'b1;
    reg_addr_in = 6'h05;
    tick(1);
    check("boot other read", access_allowed_out, 1'b0);
    reg_addr_in = 6'h00;
    tick(1);
    check("boot page zero read", access_allowed_out, 1'b1);
    reg_read_in = 1'b0;
    wait_idle;
    check("idle after boot", cmd_readback_out, 8'h00);
    cmd(8'h3f);
    check("host boot refused", cmd_readback_out, 8'h00);
    for (int k = 0; k < 3; k++) begin
      fill(k == 0 ? 1 : 2 + seed[3:0]);
      cmd(8'h12);
      check("crc running", cmd_readback_out, 8'h12);
      wait_idle;
      check("crc result", {crc_out_high_out, crc_out_low_out}, crc_of(sent));
      check("crc flag", idle_interrupt_flag_out, 1'b1);
    end
    fill(6);
    cmd(8'h0c);
    for (n = 0; n < 60 && auth_one_start_out !== 1'b1; n++) tick(1);
    check("auth start", auth_one_start_out, 1'b1);
    check("auth args", auth_args_out, packed_of(sent));
    wait_idle;
    fill(12);
    cmd(8'h19);
    wait_idle;
    check("key buffer", key_buffer_out, packed_of(sent));
    cmd(8'h14);
    tick(3);
    check("phase two running", cmd_readback_out, 8'h14);
    auth_two_done_in = 1'b1;
    tick(1);
    auth_two_done_in = 1'b0;
    tick(1);
    check("phase two flag", {cmd_readback_out, idle_interrupt_flag_out}, 9'h001);
    for (int s = 0; s < 2; s++) begin
      slow_in = s[0];
      fill(2);
      cmd(8'h07);
      for (n = 0; n < 20 && ee_out.req !== 1'b1; n++) tick(1);
      check("config address", ee_out.addr, {sent[1], sent[0]});
      wait_idle;
      check("config flag", idle_interrupt_flag_out, 1'b1);
    end
    fill(3);
    cmd(8'h14);
    tick(2);
    cmd(8'h00);
    check("abort flag", {cmd_readback_out, idle_interrupt_flag_out}, 9'h000);
    check("abort fifo level", q.size(), 3);
    q.delete();
    for (int k = 0; k < 3; k++) begin
      tick(1);
      {digital_supply_pin_in, analog_supply_pin_in, hard_reset_powerdown_pin_in} = ~(3'h4 >> k);
      tick(3);
      {digital_supply_pin_in, analog_supply_pin_in, hard_reset_powerdown_pin_in} = 3'h7;
      tick(1);
      check("boot on power event", cmd_readback_out, 8'h3f);
      wait_idle;
      check("idle after reboot", cmd_readback_out, 8'h00);
    end
    results;
  end
endmodule

bind reader_command_sequencer reader_command_sequencer_asserts chk (.ref_clk_in, .rst_n_in,
  .cmd_write_in, .cmd_data_in, .reg_read_in, .reg_addr_in, .ee_ack_in, .ee_data_in,
  .auth_two_done_in, .fifo_pop_out, .cmd_readback_out, .idle_interrupt_flag_out,
  .access_allowed_out, .ee_out, .reg_load_out, .auth_two_start_out);
